/* File: tpio_defines.svh */
/*
 * Register offsets, field positions and reset values of the three-port
 * parallel I/O block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
// How it works
// - one latch per pin, untouched by reset
// - port C has six pins, low bits
// - direction one drives pin, zero releases it
// - direction bits read/write, cleared at reset
// - output pins read back the latch
// - input pins read the pin level
// - data writes update the latches whenever byte lane 0 is enabled
// - port B pins double as converter channels
// - converter-selected input bits read zero
// - converter pins ignore port B direction
// - top port C direction bit outputs clock
// - clock enable overrides pin 2 direction
`ifndef TPIO_DEFINES_SVH
`define TPIO_DEFINES_SVH

`define TPIO_OFS_DATA_A   8'h00
`define TPIO_OFS_DATA_B   8'h01
`define TPIO_OFS_DATA_C   8'h02
`define TPIO_OFS_DIR_A    8'h04
`define TPIO_OFS_DIR_B    8'h05
`define TPIO_OFS_DIR_C    8'h06
`define TPIO_DIR_RESET    8'h00
`define TPIO_C_DATA_MASK  8'h3F
`define TPIO_C_DIR_MASK   8'hBF
`define TPIO_CLK_EN_BIT   7
`define TPIO_CLK_PIN      2
`define TPIO_ADDR_W       8

`endif

/* File: tpio_pin_model.sv */
/*
 * Pad model of one port: resolves each pad from the block and the board.
 * Assumes the board holds every released pad at a defined level.
 */
module tpio_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] drv,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] board,
    output logic      [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven pad shows the block, a released one the board level,
    // so a stale drive value can never pass for an input reading
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level[i] = oe[i] ? drv[i] : board[i];
        end
    end
endmodule // tpio_pin_model

/* File: tpio_pkg.sv */
/*
 * Types of the three-port parallel I/O block.
 * Assumes the defines header is on the include path.
 */
`include "tpio_defines.svh"
package tpio_pkg;
    // one Avalon request, carried together
    typedef struct packed {
        logic [`TPIO_ADDR_W-1:0] address;
        logic                    read;
        logic                    write;
        logic [31:0]             writedata;
    } tpio_req_t;

    // bus slave state
    typedef enum logic [0:0] {
        TPIO_IDLE,
        TPIO_DONE
    } tpio_state_t;
endpackage

/* File: tpio_read_mux.sv */
/*
 * Read-back selection of one port data register.
 * Assumes all inputs are on the bus clock.
 */
module tpio_read_mux (
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] pin,
    input  wire logic [7:0] conv_sel,
    output logic      [7:0] rd
);
    // output bits read the latch, inputs the pin, converter inputs zero
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dir[i])
                rd[i] = latch[i];
            else if (conv_sel[i])
                rd[i] = 1'b0;
            else
                rd[i] = pin[i];
        end
    end
endmodule // tpio_read_mux

/* File: tpio_sync.sv */
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the pins are asynchronous to clock.
 */
module tpio_sync (
    input  wire logic       clock,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);
    logic [7:0] meta_r;
    // first stage feeds only the second
    always_ff @(posedge clock) begin
        meta_r   <= async_in;
        sync_out <= meta_r;
    end
endmodule // tpio_sync

/* File: tpio_top.sv */
/*
 * Three parallel I/O ports with data latches and direction registers,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes pins are asynchronous; converter select and the system clock
 * level come from logic on the same clock.
 */
// Implementation choice: the Avalon-MM interface to the registers.
`include "tpio_defines.svh"
module tpio_top (
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire logic [`TPIO_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    input  wire logic [7:0]             port_a_in,
    output logic      [7:0]             port_a_out,
    output logic      [7:0]             port_a_oe,
    input  wire logic [7:0]             port_b_in,
    output logic      [7:0]             port_b_out,
    output logic      [7:0]             port_b_oe,
    input  wire logic [5:0]             port_c_in,
    output logic      [5:0]             port_c_out,
    output logic      [5:0]             port_c_oe,
    input  wire logic [4:0]             converter_channel_select,
    input  wire logic                   conv_active,
    input  wire logic                   sys_clk_level
);
    import tpio_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers
    tpio_req_t   req;
    tpio_state_t state_r;
    logic [7:0]  port_a_data_r, port_b_data_r;
    logic [5:0]  port_c_data_r;
    logic [7:0]  port_a_direction_bits_r, port_b_direction_bits_r;
    logic [5:0]  port_c_direction_bits_r;
    logic        clock_output_enable_r;
    logic [7:0]  pin_a_s, pin_b_s, pin_c_s;
    logic [7:0]  rd_a, rd_b, rd_c;
    logic [7:0]  conv_b;
    logic [7:0]  rd_nxt;
    logic        wr_go, lane0;

    assign req   = '{address: address, read: read, write: write,
                     writedata: writedata};
    assign lane0 = byteenable[0];

    // decode a channel number onto the port B pins it claims
    function automatic logic [7:0] chan_onehot(input logic [4:0] ch,
                                               input logic act);
        logic [7:0] v;
        v = 8'h00;
        if (act && ch < 5'h08)
            v[ch[2:0]] = 1'b1;
        return v;
    endfunction

    assign conv_b = chan_onehot(converter_channel_select, conv_active);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    tpio_sync u_sync_a (.clock(clock), .async_in(port_a_in),
                        .sync_out(pin_a_s));
    tpio_sync u_sync_b (.clock(clock), .async_in(port_b_in),
                        .sync_out(pin_b_s));
    tpio_sync u_sync_c (.clock(clock), .async_in({2'b00, port_c_in}),
                        .sync_out(pin_c_s));

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, answer on the second edge
    // the extra cycle lets read data come straight from a flop
    always_ff @(posedge clock) begin
        if (srst)
            state_r <= TPIO_IDLE;
        else if (state_r == TPIO_IDLE && (req.read || req.write))
            state_r <= TPIO_DONE;
        else
            state_r <= TPIO_IDLE;
    end

    // a write lands at the edge that completes the transfer, when the
    // master sees waitrequest low; the request still stands there
    assign wr_go = (state_r == TPIO_DONE) && req.write && lane0;

    // waitrequest drops for exactly the answering cycle
    always_ff @(posedge clock) begin
        if (srst)
            waitrequest <= 1'b1;
        else
            waitrequest <= !(state_r == TPIO_IDLE &&
                             (req.read || req.write));
    end

    ////////////////////////////////////////////////////////////////////
    // data latches: no reset, written whatever the direction
    always_ff @(posedge clock) begin
        if (wr_go) begin
            if (req.address == `TPIO_OFS_DATA_A)
                port_a_data_r <= req.writedata[7:0];
            else if (req.address == `TPIO_OFS_DATA_B)
                port_b_data_r <= req.writedata[7:0];
            else if (req.address == `TPIO_OFS_DATA_C)
                port_c_data_r <= req.writedata[5:0];
        end
    end

    // direction registers and clock-output enable
    always_ff @(posedge clock) begin
        if (srst) begin
            port_a_direction_bits_r <= `TPIO_DIR_RESET;
            port_b_direction_bits_r <= `TPIO_DIR_RESET;
            port_c_direction_bits_r <= 6'h00;
            clock_output_enable_r   <= 1'b0;
        end else if (wr_go) begin
            if (req.address == `TPIO_OFS_DIR_A)
                port_a_direction_bits_r <= req.writedata[7:0];
            else if (req.address == `TPIO_OFS_DIR_B)
                port_b_direction_bits_r <= req.writedata[7:0];
            else if (req.address == `TPIO_OFS_DIR_C) begin
                port_c_direction_bits_r <= req.writedata[5:0];
                clock_output_enable_r   <=
                    req.writedata[`TPIO_CLK_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path
    tpio_read_mux u_rd_a (.latch(port_a_data_r),
                          .dir(port_a_direction_bits_r),
                          .pin(pin_a_s), .conv_sel(8'h00), .rd(rd_a));
    tpio_read_mux u_rd_b (.latch(port_b_data_r),
                          .dir(port_b_direction_bits_r),
                          .pin(pin_b_s), .conv_sel(conv_b), .rd(rd_b));
    tpio_read_mux u_rd_c (.latch({2'b00, port_c_data_r}),
                          .dir({2'b00, port_c_direction_bits_r}),
                          .pin(pin_c_s), .conv_sel(8'h00), .rd(rd_c));

    // unmapped offsets read zero
    always_comb begin
        if (req.address == `TPIO_OFS_DATA_A)
            rd_nxt = rd_a;
        else if (req.address == `TPIO_OFS_DATA_B)
            rd_nxt = rd_b;
        else if (req.address == `TPIO_OFS_DATA_C)
            rd_nxt = rd_c & `TPIO_C_DATA_MASK;
        else if (req.address == `TPIO_OFS_DIR_A)
            rd_nxt = port_a_direction_bits_r;
        else if (req.address == `TPIO_OFS_DIR_B)
            rd_nxt = port_b_direction_bits_r;
        else if (req.address == `TPIO_OFS_DIR_C)
            rd_nxt = {clock_output_enable_r, 1'b0,
                      port_c_direction_bits_r};
        else
            rd_nxt = 8'h00;
    end

    always_ff @(posedge clock) begin
        if (srst)
            readdata <= 32'h0000_0000;
        else if (state_r == TPIO_IDLE && req.read)
            readdata <= {24'h00_0000, rd_nxt};
    end

    ////////////////////////////////////////////////////////////////////
    // pin drivers, all registered
    always_ff @(posedge clock) begin
        if (srst) begin
            port_a_oe <= 8'h00;
            port_b_oe <= 8'h00;
            port_c_oe <= 6'h00;
        end else begin
            port_a_oe <= port_a_direction_bits_r;
            port_b_oe <= port_b_direction_bits_r & ~conv_b;
            port_c_oe <= port_c_direction_bits_r |
                         (6'(clock_output_enable_r) << `TPIO_CLK_PIN);
        end
    end

    // the clock on pin 2 is a sampled copy; it lags by one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            port_a_out <= 8'h00;
            port_b_out <= 8'h00;
            port_c_out <= 6'h00;
        end else begin
            port_a_out <= port_a_data_r;
            port_b_out <= port_b_data_r;
            port_c_out <= port_c_data_r;
            if (clock_output_enable_r)
                port_c_out[`TPIO_CLK_PIN] <= sys_clk_level;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // srst may fall with the clock edge itself, and disable iff sees the
    // current value, so that edge is not masked; a !$past(srst) guard
    // keeps history from before the reset out of those checks

    // reset state of the direction side
    dir_reset_a: assert property (@(posedge clock)
        srst |=> port_a_direction_bits_r == 8'h00 &&
        port_b_direction_bits_r == 8'h00 &&
        port_c_direction_bits_r == 6'h00 && !clock_output_enable_r)
        else $error("direction not cleared");

    // pad enables follow the direction bits one cycle later, except converter pins, which stay released, and clock pin 2
    oe_follow_a: assert property (@(posedge clock)
        disable iff (srst) !$past(srst) |->
        port_a_oe == $past(port_a_direction_bits_r))
        else $error("port a enable wrong");
    oe_c_follow_a: assert property (@(posedge clock)
        disable iff (srst) !$past(srst) |->
        port_c_oe[1:0] == $past(port_c_direction_bits_r[1:0]) &&
        port_c_oe[5:3] == $past(port_c_direction_bits_r[5:3]))
        else $error("port c enable wrong");
    conv_release_a: assert property (@(posedge clock)
        disable iff (srst) !$past(srst) |->
        ($past(conv_b) & port_b_oe) == 8'h00)
        else $error("converter pin driven");

    // clock output on pin 2 overrides its direction bit
    clk_pin_a: assert property (@(posedge clock)
        disable iff (srst) !$past(srst) &&
        $past(clock_output_enable_r) |-> port_c_oe[2])
        else $error("clock pin not driven");
    clk_level_a: assert property (@(posedge clock)
        disable iff (srst) !$past(srst) &&
        $past(clock_output_enable_r) |->
        port_c_out[`TPIO_CLK_PIN] == $past(sys_clk_level))
        else $error("clock pin level wrong");

    // register writes land at the answering edge
    latch_write_a: assert property (@(posedge clock)
        disable iff (srst) wr_go && address == `TPIO_OFS_DATA_A |=>
        port_a_data_r == $past(writedata[7:0]))
        else $error("latch not written");
    latch_b_write_a: assert property (@(posedge clock)
        disable iff (srst) wr_go && address == `TPIO_OFS_DATA_B |=>
        port_b_data_r == $past(writedata[7:0]))
        else $error("port b latch not written");
    latch_c_write_a: assert property (@(posedge clock)
        disable iff (srst) wr_go && address == `TPIO_OFS_DATA_C |=>
        port_c_data_r == $past(writedata[5:0]))
        else $error("port c latch not written");
    dir_write_a: assert property (@(posedge clock)
        disable iff (srst) wr_go && address == `TPIO_OFS_DIR_B |=>
        port_b_direction_bits_r == $past(writedata[7:0]))
        else $error("port b direction not written");
    dirc_write_a: assert property (@(posedge clock)
        disable iff (srst) wr_go && address == `TPIO_OFS_DIR_C |=>
        port_c_direction_bits_r == $past(writedata[5:0]) &&
        clock_output_enable_r == $past(writedata[`TPIO_CLK_EN_BIT]))
        else $error("port c direction not written");

    // read data, loaded at the edge that takes the request
    read_out_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DATA_A &&
        port_a_direction_bits_r == 8'hFF |=>
        readdata[7:0] == $past(port_a_data_r))
        else $error("output read not latch");
    read_b_out_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DATA_B |=>
        (readdata[7:0] & $past(port_b_direction_bits_r)) ==
        $past(port_b_data_r & port_b_direction_bits_r))
        else $error("port b output read wrong");
    read_in_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DATA_A |=>
        (readdata[7:0] & ~$past(port_a_direction_bits_r)) ==
        ($past(pin_a_s) & ~$past(port_a_direction_bits_r)))
        else $error("input read not pin");
    conv_zero_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DATA_B |=>
        (readdata[7:0] & $past(conv_b & ~port_b_direction_bits_r)) == 8'h00)
        else $error("converter input not zero");
    datac_read_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DATA_C |=>
        readdata[7:6] == 2'b00)
        else $error("port c upper bits not zero");
    dirc_read_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address == `TPIO_OFS_DIR_C |=>
        readdata[6] == 1'b0 && readdata[7] == $past(clock_output_enable_r))
        else $error("port c direction read wrong");
    unmapped_read_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && read && address > `TPIO_OFS_DATA_C &&
        address < `TPIO_OFS_DIR_A |=> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (@(posedge clock)
        disable iff (srst) readdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    // one answer per request, and data that stands until the next read
    answer_a: assert property (@(posedge clock)
        disable iff (srst)
        state_r == TPIO_IDLE && (read || write) |=> !waitrequest)
        else $error("request not answered");
    wait_once_a: assert property (@(posedge clock)
        disable iff (srst) !waitrequest |=> waitrequest)
        else $error("two answers in a row");
    read_hold_a: assert property (@(posedge clock)
        disable iff (srst)
        !(state_r == TPIO_IDLE && read) |=> $stable(readdata))
        else $error("read data did not stand");
endmodule // tpio_top

/* File: tpio_top_bench.sv */
/*
 * Self-checking bench of the three-port I/O block over its Avalon slave.
 * Assumes the package, design files and pad model are compiled first.
 */
`include "tpio_defines.svh"
module tpio_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tpio_pkg::*;
    logic        clock, srst, read, write, waitrequest, conv_active;
    logic        sys_clk_level;
    logic [7:0]  address, a_out, a_oe, a_in, b_out, b_oe, b_in, m, e;
    logic [5:0]  c_out, c_oe, c_in;
    logic [31:0] writedata, readdata, rd;
    logic [3:0]  byteenable;
    logic [4:0]  sel;
    logic [7:0]  ext [3];
    int          n_errors, n_compared, p, n;
    ////////////////////////////////////////////////////////////////////////
    tpio_top dut_u (.clock(clock), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .port_a_in(a_in), .port_a_out(a_out),
        .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out),
        .port_b_oe(b_oe), .port_c_in(c_in), .port_c_out(c_out),
        .port_c_oe(c_oe), .converter_channel_select(sel),
        .conv_active(conv_active), .sys_clk_level(sys_clk_level));
    tpio_pin_model #(.W(8)) pin_a_u (.drv(a_out), .oe(a_oe),
        .board(ext[0]), .level(a_in));
    tpio_pin_model #(.W(8)) pin_b_u (.drv(b_out), .oe(b_oe),
        .board(ext[1]), .level(b_in));
    tpio_pin_model #(.W(6)) pin_c_u (.drv(c_out), .oe(c_oe),
        .board(ext[2][5:0]), .level(c_in));
    ////////////////////////////////////////////////////////////////////////
    // verdict in one place, also reached by a bus timeout
    task automatic wrap_up();
        $display("compared %0d, wrong %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer; waits an edge first so the strobe drops for a cycle
    task automatic bus(input logic is_wr, input logic [7:0] adr,
                       input logic [7:0] wd, input logic [3:0] be);
        int i;
        @(posedge clock);
        address    <= adr;
        writedata  <= {24'h000000, wd};
        byteenable <= be;
        read       <= ~is_wr;
        write      <= is_wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        bus(1'b1, a, d, be);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00, 4'h1);
        check(rd, {24'h000000, x});
    endtask
    // pin levels pass a two-flop synchroniser, so let them settle
    task automatic idle(input int k);
        repeat (k) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        srst = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00;
        writedata = 32'h00000000; byteenable = 4'h0; sel = 5'h00;
        conv_active = 1'b0; sys_clk_level = 1'b0; n_errors = 0;
        n_compared = 0; ext[0] = 8'h3C; ext[1] = 8'hFF; ext[2] = 8'h15;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        for (p = 0; p < 3; p++) rdc(8'(p + 4), `TPIO_DIR_RESET);
        check({8'h00, a_oe, b_oe, 2'h0, c_oe}, 32'h0);
        $display("test reset done");
        // data first, then direction: inputs read pins, outputs latches
        for (p = 0; p < 3; p++) begin
            m = (p == 2) ? `TPIO_C_DATA_MASK : 8'hFF;
            wr(8'(p), 8'hA5);
            idle(4);
            rdc(8'(p), ext[p] & m);
            wr(8'(p + 4), 8'h3C);
            idle(4);
            rdc(8'(p + 4), 8'h3C);
            rdc(8'(p), (8'h24 | (ext[p] & 8'hC3)) & m);
        end
        check({8'h00, a_oe, b_oe, 2'h0, c_oe}, 32'h003C3C3C);
        check({a_out, b_out, 2'h0, c_out} & 24'h3C3C3C, 24'h242424);
        $display("test direction done");
        // clock out with pin 2 direction clear and bit 6 written
        wr(`TPIO_OFS_DIR_C, 8'hC0);
        rdc(`TPIO_OFS_DIR_C, 8'h80);
        sys_clk_level <= 1'b1;
        idle(4);
        check({c_oe[2], c_out[2]}, 2'b11);
        sys_clk_level <= 1'b0;
        idle(4);
        check({c_oe[2], c_out[2]}, 2'b10);
        wr(`TPIO_OFS_DIR_C, 8'h3C);
        idle(2);
        check(c_oe, 6'h3C);
        $display("test clock out done");
        // every converter channel on port B, then one outside it
        for (n = 0; n < 8; n++) begin
            e = 8'(1 << n);
            sel <= 5'(n);
            conv_active <= 1'b1;
            idle(4);
            rdc(`TPIO_OFS_DATA_B, 8'h24 | (8'hC3 & ~e));
            check(b_oe, 8'h3C & ~e);
        end
        sel <= 5'h08;
        idle(4);
        rdc(`TPIO_OFS_DATA_B, 8'hE7);
        conv_active <= 1'b0;
        $display("test converter done");
        // refused writes, unmapped place, latches across a reset
        wr(`TPIO_OFS_DATA_A, 8'h5A, 4'h0);
        wr(8'h03, 8'hFF);
        rdc(8'h03, 8'h00);
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        wr(`TPIO_OFS_DIR_A, 8'hFF);
        rdc(`TPIO_OFS_DATA_A, 8'hA5);
        $display("test refusal and reset done");
        wrap_up();
    end
endmodule // tpio_top_bench
